// *** logic/rwc_regulator_wake_control.sv ***
// Regulator wake latch with real-time counter and register ports
// How it works
// - Wake sources latch regulator on until fabric clears
// - Keep-on high holds; falling edge commands shutdown
// - Wake pin low keeps regulator on always
// - Active JTAG forces on, ignores shutdown
// - Initial-off still powers up unless JTAG reset low
// - Enabled compare hit triggers regulator power-up
// - Loadable 40-bit counter, equality compare, optional clear
// - Counter ticks from 7-bit prescaler, oscillator enabled
// - Counter and compare via config port and JTAG
// - Supply valid clears counter and compare
// - Hit output high exactly when values equal
// - 8-bit control status register governs counter
// - Unit reset released two edges after clearing
// - Count release bit must be one to count
// - Compare wake enable gates hit to regulator
// - Clear-on-compare resets counter on hit
// - Count enable bit stops or runs counter
// - Standby: hit or wake pin turns on
// - Sleep: only wake pin or active JTAG turns regulator on
// - JTAG release without wake pin delays 100 us
// - Wake pin is active low, idles high
// - Wake pin level output is inverse of pin
// - Power good starts at initial-on, rises on wake
`timescale 1ns/10ps

module rwc_regulator_wake_control #(
  parameter int unsigned JTAG_DELAY = rwc_pkg::JTAG_DELAY_CYCLES
) (
  // Clock and reset (reset marks the 3.3 V supply becoming valid)
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // Wake sources and shutdown command
  input  wire logic                       wake_pin_n,
  input  wire logic                       regulator_keep_on,
  input  wire logic                       jtagTestReset,
  input  wire logic                       regulator_initial_on,
  // Crystal oscillator tick, one-cycle enable
  input  wire logic                       xtalTick,
  // Config mux register port
  input  rwc_pkg::rwc_access_t            config_mux_port,
  output logic [rwc_pkg::DATA_W-1:0]      cfgRdata,
  // JTAG register port
  input  rwc_pkg::rwc_access_t            jtagAccess,
  output logic [rwc_pkg::DATA_W-1:0]      jtagRdata,
  // Regulator and status outputs
  output logic                            regulatorEnable,
  output logic                            fabric_power_good,
  output logic                            wake_pin_level,
  output logic                            counter_wake_hit
);
  import rwc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [COUNT_W-1:0] countReg;        // Real-time counter
  logic [COUNT_W-1:0] countNext;       // Counter next value
  logic [COUNT_W-1:0] compareReg;      // Compare register
  logic [COUNT_W-1:0] compareNext;     // Compare next value
  logic [DATA_W-1:0]  ctrlReg;         // Control status
  logic [PRESC_W-1:0] prescReg;        // Prescaler
  logic [1:0]         unitRstPipeReg;  // Unit reset release pipe
  logic               hitPrevReg;      // Hit seen last cycle
  logic               keepPrevReg;     // Keep-on seen last cycle
  logic               trstPrevReg;     // Test reset seen last cycle
  logic               jtagArmedReg;    // JTAG force allowed
  logic [DELAY_W-1:0] delayReg;        // Re-power delay counter
  logic               initDoneReg;     // Power-up decision taken
  logic               onNext;          // Regulator next state

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire               cfgWr     = config_mux_port.wr;
  wire               anyWr     = config_mux_port.wr | jtagAccess.wr;
  // Config port wins when both write in one cycle
  wire [ADDR_W-1:0]  wrAddr    = cfgWr ? config_mux_port.addr
                                       : jtagAccess.addr;
  wire [DATA_W-1:0]  wrData    = cfgWr ? config_mux_port.wdata
                                       : jtagAccess.wdata;
  wire               ctrlWr    = config_mux_port.wr &&
                                 config_mux_port.addr == ADDR_CTRL;
  wire               unitRst   = ~unitRstPipeReg[1];
  wire               oscOn     = ctrlReg[CTRL_OSC_EN];
  wire               counting  = ctrlReg[CTRL_COUNT_REL] &
                                 ctrlReg[CTRL_COUNT_EN] & ~unitRst;
  wire               prescWrap = prescReg == PRESC_W'(7'h7f);
  wire               tick      = xtalTick & oscOn & prescWrap &
                                 counting;
  wire               hitNow    = countReg == compareReg;
  wire               hitRise   = counter_wake_hit & ~hitPrevReg;
  wire               cmpWake   = hitRise & ctrlReg[CTRL_CMP_WAKE];
  wire               pinWake   = ~wake_pin_n;
  wire               jtagForce = jtagTestReset & jtagArmedReg;
  wire               keepFall  = keepPrevReg & ~regulator_keep_on;
  wire               trstRise  = jtagTestReset & ~trstPrevReg;
  wire               initWake  = ~initDoneReg &
                                 (regulator_initial_on | jtagTestReset);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  function automatic logic [DATA_W-1:0] readByte(
    input logic [ADDR_W-1:0] a
  );
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < COUNT_BYTES; i++) begin
      if (a == ADDR_COUNT0 + ADDR_W'(i)) begin
        r = countReg[DATA_W*i +: DATA_W];
      end
      if (a == ADDR_COMPARE0 + ADDR_W'(i)) begin
        r = compareReg[DATA_W*i +: DATA_W];
      end
    end
    if (a == ADDR_CTRL) begin
      r = (ctrlReg & CTRL_WR_MASK) | (DATA_W'(counter_wake_hit)
          << CTRL_HIT_STAT);
    end
    return r;
  endfunction

  // ****************************************************************
  // Counter and compare next values
  // ****************************************************************
  // Writes win over counting; byte lanes per index
  always_comb begin
    countNext   = countReg;
    compareNext = compareReg;
    if (unitRst) begin
      countNext = '0;
    end else if (tick) begin
      // Clear on compare gives periodic events
      if (hitNow && ctrlReg[CTRL_CLR_ON_CMP]) begin
        countNext = '0;
      end else begin
        countNext = countReg + COUNT_W'(1);
      end
    end
    for (int i = 0; i < COUNT_BYTES; i++) begin
      if (anyWr && wrAddr == ADDR_COUNT0 + ADDR_W'(i)) begin
        countNext[DATA_W*i +: DATA_W] = wrData;
      end
      if (anyWr && wrAddr == ADDR_COMPARE0 + ADDR_W'(i)) begin
        compareNext[DATA_W*i +: DATA_W] = wrData;
      end
    end
  end

  // ****************************************************************
  // Regulator latch next value
  // ****************************************************************
  // Any source sets; set wins over the fabric's clear
  always_comb begin
    onNext = regulatorEnable;
    if (keepFall) begin
      onNext = 1'b0;
    end
    if (pinWake || cmpWake || jtagForce || initWake) begin
      onNext = 1'b1;
    end
  end

  // ****************************************************************
  // Counter, compare and hit flops
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      countReg         <= '0;
      compareReg       <= '0;
      counter_wake_hit <= 1'b1;
    end else begin
      countReg         <= countNext;
      compareReg       <= compareNext;
      counter_wake_hit <= countNext == compareNext;
    end
  end

  // ****************************************************************
  // Control status, prescaler and unit reset pipe
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg        <= CTRL_RESET;
      prescReg       <= '0;
      unitRstPipeReg <= '0;
    end else begin
      if (ctrlWr) begin
        ctrlReg <= config_mux_port.wdata & CTRL_WR_MASK;
      end
      // Unit reset clears pipe, release shifts in ones
      if (ctrlReg[CTRL_UNIT_RESET]) begin
        unitRstPipeReg <= '0;
      end else begin
        unitRstPipeReg <= {unitRstPipeReg[0], 1'b1};
      end
      // Prescaler clears with oscillator off or unit in reset
      if (unitRst || !oscOn) begin
        prescReg <= '0;
      end else if (xtalTick) begin
        prescReg <= prescReg + PRESC_W'(1);
      end
    end
  end

  // ****************************************************************
  // JTAG re-power delay
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trstPrevReg  <= 1'b0;
      jtagArmedReg <= 1'b0;
      delayReg     <= '0;
    end else begin
      trstPrevReg <= jtagTestReset;
      if (!jtagTestReset) begin
        jtagArmedReg <= 1'b0;
      end else if (trstRise) begin
        // Wake pin low at release skips the delay
        jtagArmedReg <= pinWake;
        delayReg     <= DELAY_W'(JTAG_DELAY);
      end else if (!jtagArmedReg) begin
        if (delayReg <= DELAY_W'(1)) begin
          jtagArmedReg <= 1'b1;
        end
        delayReg <= delayReg - DELAY_W'(1);
      end
    end
  end

  // ****************************************************************
  // Regulator, power good and status outputs
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regulatorEnable   <= 1'b0;
      fabric_power_good <= 1'b0;
      wake_pin_level    <= 1'b0;
      initDoneReg       <= 1'b0;
      keepPrevReg       <= 1'b0;
      // Hit starts high, so no false rising edge after reset
      hitPrevReg        <= 1'b1;
      cfgRdata          <= '0;
      jtagRdata         <= '0;
    end else begin
      regulatorEnable   <= onNext;
      fabric_power_good <= onNext;
      wake_pin_level    <= ~wake_pin_n;
      initDoneReg       <= 1'b1;
      keepPrevReg       <= regulator_keep_on;
      hitPrevReg        <= counter_wake_hit;
      if (config_mux_port.rd) begin
        cfgRdata <= readByte(config_mux_port.addr);
      end
      if (jtagAccess.rd) begin
        jtagRdata <= readByte(jtagAccess.addr);
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Held on the edge after the clear and on the one after that
  sequence s_unitHeld;
    $past(unitRst) && unitRst;
  endsequence
  sequence s_unitFree;
    !unitRst;
  endsequence

  a_hit_equal: assert property (
    counter_wake_hit == (countReg == compareReg))
    else $error("compare hit disagrees with counter and compare");
  a_pin_keeps_on: assert property (
    pinWake |=> regulatorEnable)
    else $error("regulator off while wake pin low");
  a_pin_level: assert property (
    wake_pin_level == !$past(wake_pin_n))
    else $error("wake pin level not inverse of pin");
  a_jtag_force: assert property (
    jtagForce |=> regulatorEnable && fabric_power_good)
    else $error("regulator off while JTAG active");
  a_latch_holds: assert property (
    regulatorEnable && !keepFall |=> regulatorEnable)
    else $error("regulator dropped without shutdown command");
  a_keep_fall_off: assert property (
    regulatorEnable && keepFall && !pinWake && !cmpWake && !jtagForce
    && initDoneReg |=> !regulatorEnable)
    else $error("shutdown command ignored");
  a_cmp_wake: assert property (
    cmpWake |=> regulatorEnable)
    else $error("compare wake did not power regulator");
  a_count_stop: assert property (
    !ctrlReg[CTRL_COUNT_EN] && !unitRst && !anyWr |=> $stable(countReg))
    else $error("counter moved while disabled");
  a_clear_cmp: assert property (
    tick && hitNow && ctrlReg[CTRL_CLR_ON_CMP] && !anyWr
    |=> countReg == '0)
    else $error("counter not cleared on compare");
  a_unit_release: assert property (
    $fell(ctrlReg[CTRL_UNIT_RESET]) ##1 !ctrlReg[CTRL_UNIT_RESET]
    |-> s_unitHeld ##1 s_unitFree)
    else $error("unit reset release not after two edges");
  a_jtag_delay: assert property (
    trstRise && !pinWake |=> !jtagArmedReg[*8])
    else $error("JTAG force came before re-power delay");

endmodule

// *** logic/rwc_pkg.sv ***
// Constants and carrier types for the regulator wake control block
package rwc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 20;     // Core clock period
  localparam int unsigned JTAG_DELAY_NS      = 100000; // Re-power delay
  // Least time, so round up to whole cycles
  localparam int unsigned JTAG_DELAY_CYCLES  =
    (JTAG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_W            = 16;     // Delay counter width

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned COUNT_W    = 40;  // Counter and compare width
  localparam int unsigned PRESC_W    = 7;   // Prescaler width
  localparam int unsigned DATA_W     = 8;   // Register port data width
  localparam int unsigned ADDR_W     = 4;   // Register port address width
  localparam int unsigned COUNT_BYTES = COUNT_W / DATA_W;

  // ****************************************************************
  // Register map, one byte per index
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_COUNT0   = 4'h0; // Counter bytes 0..4
  localparam logic [ADDR_W-1:0] ADDR_COMPARE0 = 4'h5; // Compare bytes 5..9
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'ha; // Control status

  // ****************************************************************
  // Control status fields
  // ****************************************************************
  localparam int unsigned CTRL_UNIT_RESET   = 0; // Counter unit reset
  localparam int unsigned CTRL_COUNT_REL    = 1; // Count release
  localparam int unsigned CTRL_CMP_WAKE     = 2; // Compare wake enable
  localparam int unsigned CTRL_CLR_ON_CMP   = 3; // Clear on compare
  localparam int unsigned CTRL_COUNT_EN     = 4; // Count enable
  localparam int unsigned CTRL_OSC_EN       = 5; // Crystal oscillator on
  localparam int unsigned CTRL_HIT_STAT     = 7; // Compare hit, read only
  localparam logic [DATA_W-1:0] CTRL_RESET  = 8'h01; // Unit held in reset
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'h3f; // Writable bits

  // ****************************************************************
  // Carrier for one register access
  // ****************************************************************
  typedef struct packed {
    logic              wr;    // Write strobe
    logic              rd;    // Read strobe
    logic [ADDR_W-1:0] addr;  // Byte index
    logic [DATA_W-1:0] wdata; // Write data
  } rwc_access_t;

endpackage

// *** verification/rwc_fabric_model.sv ***
// Fabric-side model driving the regulator keep-on input
`timescale 1ns/10ps

module rwc_fabric_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Status from the block and test controls
  input  wire logic       powerGood,
  input  wire logic       shutReq,
  input  wire logic [3:0] lag,
  // Keep-on drive
  output logic            keepOn
);
  logic       holdLow; // Shutdown under way
  logic [3:0] waitCnt; // Cycles of power good seen

  // Raise keep-on only after power good, drop it on request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      keepOn  <= 1'b0;
      holdLow <= 1'b0;
      waitCnt <= 4'h0;
    end else if (holdLow) begin
      // Stay low while the request stands and power remains
      holdLow <= powerGood & shutReq;
      waitCnt <= 4'h0;
    end else if (shutReq && keepOn) begin
      // Falling edge is the shutdown command
      keepOn  <= 1'b0;
      holdLow <= 1'b1;
    end else if (!powerGood) begin
      // No fabric power, nothing driven high
      keepOn  <= 1'b0;
      waitCnt <= 4'h0;
    end else if (waitCnt == lag) begin
      keepOn  <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// *** verification/test_regulator_wake_control.sv ***
// Self-checking testbench for the regulator wake control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin \
  miscompares++; $display("wrong value %s exp %0h got %0h", n, e, g); \
  end end

module test_regulator_wake_control;
  import rwc_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        core_clk;    // 50 MHz clock
  logic        rst_n;       // Supply-valid reset
  logic        wakeN;       // Wake pin, idles high
  logic        keepOn;      // Keep-on from fabric model
  logic        jtagRst;     // JTAG test reset pin
  logic        initOn;      // Initial-on setting
  logic        xtalTick;    // Oscillator tick
  logic        xtalRun;     // Oscillator running
  logic        shutReq;     // Shutdown request to model
  logic [3:0]  lag;         // Model answer delay
  rwc_access_t cfgPort;     // Config port request
  rwc_access_t jtagPort;    // JTAG port request
  logic [7:0]  cfgRdata;    // Config read data
  logic [7:0]  jtagRdata;   // JTAG read data
  logic        regEn;       // Regulator on
  logic        pGood;       // Fabric power good
  logic        wakeLevel;   // Inverted wake pin
  logic        hit;         // Compare hit
  int          miscompares; // Mismatch count
  int          cmpCount;    // Comparison count

  // Clock and oscillator tick every other cycle
  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) xtalTick <= xtalRun & ~xtalTick;

  rwc_regulator_wake_control #(.JTAG_DELAY(10)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .wake_pin_n(wakeN),
    .regulator_keep_on(keepOn), .jtagTestReset(jtagRst),
    .regulator_initial_on(initOn), .xtalTick(xtalTick),
    .config_mux_port(cfgPort), .cfgRdata(cfgRdata),
    .jtagAccess(jtagPort), .jtagRdata(jtagRdata),
    .regulatorEnable(regEn), .fabric_power_good(pGood),
    .wake_pin_level(wakeLevel), .counter_wake_hit(hit));

  rwc_fabric_model fab (
    .core_clk(core_clk), .rst_n(rst_n), .powerGood(pGood),
    .shutReq(shutReq), .lag(lag), .keepOn(keepOn));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // One register access on either port, held over one rising edge
  task automatic acc(input bit jt, input bit wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    rwc_access_t x;
    x = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge core_clk);
    if (jt) jtagPort = x;
    else cfgPort = x;
    @(negedge core_clk);
    cfgPort = '0;
    jtagPort = '0;
    r = jt ? jtagRdata : cfgRdata;
  endtask

  // Reset with given setting and JTAG level
  task automatic do_reset(input logic io, input logic jt);
    @(negedge core_clk);
    rst_n = 1'b0;
    initOn = io;
    jtagRst = jt;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  // Fabric shutdown request, then judge the regulator
  task automatic shut_cmd(input logic expEn);
    @(negedge core_clk);
    shutReq = 1'b1;
    repeat (30) @(negedge core_clk);
    `CHK("regEn", expEn, regEn)
    `CHK("pGood", expEn, pGood)
    shutReq = 1'b0;
  endtask

  // Wait for hit to reach a level, bounded
  task automatic wait_hit(input logic lvl, output int n);
    n = 0;
    while (hit !== lvl && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // Verdict and end of run
  task automatic wrapUp();
    if (miscompares == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Power-up decision and register reset values
  task automatic t_reset();
    logic [7:0] r;
    logic [2:0] tbl [3] = '{3'b101, 3'b011, 3'b000}; // init,jtag,exp
    for (int i = 0; i < 3; i++) begin
      do_reset(tbl[i][2], tbl[i][1]);
      `CHK("upEn", tbl[i][0], regEn)
      `CHK("upGood", tbl[i][0], pGood)
    end
    `CHK("hit0", 1'b1, hit)
    acc(0, 0, ADDR_CTRL, 8'h00, r);
    `CHK("ctrl", 8'h81, r)
    acc(0, 0, ADDR_COUNT0 + 4'h4, 8'h00, r);
    `CHK("cnt4", 8'h00, r)
    acc(1, 0, ADDR_COMPARE0 + 4'h4, 8'h00, r);
    `CHK("cmp4", 8'h00, r)
  endtask

  // Both ports, compare output, unmapped index
  task automatic t_regs();
    logic [7:0] r;
    // Release unit reset with counting off, so counter bytes stay put
    acc(0, 1, ADDR_CTRL, 8'h00, r);
    acc(0, 1, ADDR_COMPARE0, 8'h10, r);
    `CHK("hitOff", 1'b0, hit)
    acc(1, 0, ADDR_COMPARE0, 8'h00, r);
    `CHK("jtagCmp", 8'h10, r)
    acc(1, 1, ADDR_COUNT0, 8'h10, r);
    `CHK("hitOn", 1'b1, hit)
    acc(0, 0, ADDR_COUNT0, 8'h00, r);
    `CHK("cfgCnt", 8'h10, r)
    acc(0, 1, 4'hb, 8'h5a, r);
    acc(0, 0, 4'hb, 8'h00, r);
    `CHK("unmapped", 8'h00, r)
  endtask

  // Wake pin holds on, then shutdown clears the latch
  task automatic t_wake();
    @(negedge core_clk);
    wakeN = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("pinEn", 1'b1, regEn)
    `CHK("pinLvl", 1'b1, wakeLevel)
    shut_cmd(1'b1);
    wakeN = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("pinIdle", 1'b0, wakeLevel)
    shut_cmd(1'b0);
  endtask

  // JTAG active forces on after the delay, blocks shutdown
  task automatic t_jtag();
    @(negedge core_clk);
    jtagRst = 1'b1;
    repeat (5) @(negedge core_clk);
    `CHK("jtDelay", 1'b0, regEn)
    repeat (15) @(negedge core_clk);
    `CHK("jtOn", 1'b1, regEn)
    shut_cmd(1'b1);
    jtagRst = 1'b0;
    shut_cmd(1'b0);
    // Wake pin low as JTAG leaves reset arms the force at once
    @(negedge core_clk);
    wakeN = 1'b0;
    jtagRst = 1'b1;
    @(negedge core_clk);
    wakeN = 1'b1;
    @(negedge core_clk);
    shutReq = 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK("jtFast", 1'b1, regEn)
    shutReq = 1'b0;
    jtagRst = 1'b0;
    shut_cmd(1'b0);
  endtask

  // Counter rate, compare wake, clear and freeze controls
  task automatic t_count();
    logic [7:0] r;
    logic [7:0] r2;
    int         n;
    logic [7:0] frz [3] = '{8'h2a, 8'h38, 8'h3f};
    acc(0, 1, ADDR_COUNT0, 8'h00, r);
    acc(0, 1, ADDR_COMPARE0, 8'h02, r);
    acc(0, 1, ADDR_CTRL, 8'h3e, r);
    xtalRun = 1'b1;
    wait_hit(1'b1, n);
    `CHK("rate", 1'b1, n inside {[480:540]})
    repeat (2) @(negedge core_clk);
    `CHK("cmpWake", 1'b1, regEn)
    wait_hit(1'b0, n);
    `CHK("clrOnCmp", 1'b1, n < 300)
    // Without the clear the counter would read 3 here
    acc(0, 0, ADDR_COUNT0, 8'h00, r);
    `CHK("clrCnt", 8'h00, r)
    shut_cmd(1'b0);
    acc(0, 1, ADDR_CTRL, 8'h3a, r);
    wait_hit(1'b1, n);
    repeat (2) @(negedge core_clk);
    `CHK("noWake", 1'b0, regEn)
    for (int i = 0; i < 3; i++) begin
      acc(0, 1, ADDR_CTRL, frz[i], r);
      repeat (4) @(negedge core_clk);
      acc(0, 0, ADDR_COUNT0, 8'h00, r);
      repeat (600) @(negedge core_clk);
      acc(0, 0, ADDR_COUNT0, 8'h00, r2);
      `CHK("frozen", r, r2)
    end
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    wakeN = 1'b1;
    jtagRst = 1'b0;
    initOn = 1'b0;
    xtalRun = 1'b0;
    xtalTick = 1'b0;
    shutReq = 1'b0;
    lag = 4'h9;
    cfgPort = '0;
    jtagPort = '0;
    miscompares = 0;
    cmpCount = 0;
    t_reset();
    t_regs();
    t_wake();
    lag = 4'h0;
    t_jtag();
    t_count();
    wrapUp();
  end

  // Cut a hang short, about six times the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    wrapUp();
  end
endmodule
